// [shared/otpps_regs.svh]
// Purpose: Constants for the one-time-programmable memory programmer
// Assumes: 250 MHz mclk
// Notes: Times in ns, counts derived from the clock period
`ifndef OTPPS_REGS_SVH
`define OTPPS_REGS_SVH
`define OTPPS_CLK_NS 4
`define OTPPS_PW_NOM_NS 50000
`define OTPPS_PW_MIN_NS 47500
`define OTPPS_PW_MAX_NS 52500
`define OTPPS_PW_CYC (`OTPPS_PW_NOM_NS / `OTPPS_CLK_NS)
`define OTPPS_SETUP_NS 2000
`define OTPPS_SETUP_CYC \
   ((`OTPPS_SETUP_NS + `OTPPS_CLK_NS - 1) / `OTPPS_CLK_NS)
`define OTPPS_TOE_NS 150
`define OTPPS_TOE_CYC ((`OTPPS_TOE_NS + `OTPPS_CLK_NS - 1) / `OTPPS_CLK_NS)
`define OTPPS_RETRY_MAX 10
`define OTPPS_ID_ADDR_BIT 9
`define OTPPS_ID_SEL_BIT 0
`endif

// [shared/otpps_pkg.sv]
// Purpose: Types for the programmer
// Assumes: Nothing
// Notes: State list of the sequencer
package otpps_pkg;
   typedef enum logic [3:0] {
      OTPPS_IDLE, OTPPS_PWR_UP, OTPPS_SET, OTPPS_PULSE, OTPPS_VRD,
      OTPPS_VCMP, OTPPS_PWR_DN, OTPPS_RB, OTPPS_RBCMP, OTPPS_IDRD,
      OTPPS_DONE
   } otpps_state_e;
   typedef enum logic [1:0] {
      OTPPS_PH_FIRST, OTPPS_PH_VERIFY, OTPPS_PH_READ
   } otpps_phase_e;
endpackage

// [verilog/otpps_programmer.sv]
// Purpose: Drives a 32K x 16 OTP memory through program, verify, read-back
// Assumes: Source words come from a same-clock lookup port, one cycle late
// Notes: Supplies are switched by level outputs; data pins are two-way
//
// How it works
// - Strobe pulse held 50 us, within 47.5..52.5
// - Sequence starts at address zero
// - First pass: one pulse per word, no verify
// - Failing word gets up to 10 more pulses
// - Still failing after 10 retries: declare fail
// - Verified word advances address until all checked
// - Supplies to nominal, read back, compare until first mismatch
// - Raise id line for identification readout
// - Main supply on first, off last
// - ID readout: other addresses low, enables low
`include "otpps_regs.svh"
`timescale 1ns/1ns
`default_nettype none
module otpps_programmer #(
   parameter int AW = 15,
   parameter int DW = 16,
   parameter int PW_CYC = `OTPPS_PW_CYC
) (
   input wire logic mclk,
   input wire logic srst,
   input wire logic start_prog,
   input wire logic start_id,
   input wire logic id_sel,
   input wire logic [DW-1:0] src_data,
   output logic [AW-1:0] src_addr,
   output logic [AW-1:0] mem_addr,
   output logic [DW-1:0] data_out,
   output logic data_oe_n,
   input wire logic [DW-1:0] data_outputs,
   output logic chip_en_n,
   output logic out_en_n,
   output logic program_strobe_n,
   output logic id_mode_high_voltage_line,
   output logic vcc_prog,
   output logic vpp_prog,
   output logic busy,
   output logic done,
   output logic pass,
   output logic [DW-1:0] id_word
);
   // Wait counter must hold the longest of pulse, set-up and read waits
   localparam int CMAX0 = (PW_CYC > `OTPPS_SETUP_CYC) ? PW_CYC :
      `OTPPS_SETUP_CYC;
   localparam int CMAX = (CMAX0 > `OTPPS_TOE_CYC) ? CMAX0 : `OTPPS_TOE_CYC;
   localparam int CW = $clog2(CMAX + 1);
   localparam logic [CW-1:0] PW_C = CW'(PW_CYC);
   localparam logic [CW-1:0] SU_C = CW'(`OTPPS_SETUP_CYC);
   localparam logic [CW-1:0] OE_C = CW'(`OTPPS_TOE_CYC);
   localparam logic [3:0] RMAX = 4'(`OTPPS_RETRY_MAX);
   localparam logic [AW-1:0] ALAST = '1;

   ////////////////////////////////////////////////////////////////////////
   // Pin synchroniser
   logic [DW-1:0] din_s1_r, din_s2_r;
   always_ff @(posedge mclk) begin
      din_s1_r <= data_outputs;
      din_s2_r <= din_s1_r;
   end

   ////////////////////////////////////////////////////////////////////////
   // Sequencer
   otpps_pkg::otpps_state_e st_r, st_nxt;
   otpps_pkg::otpps_phase_e ph_r;
   logic [CW-1:0] cnt_r;
   logic [3:0] retry_r;
   logic [AW-1:0] addr_r;
   logic [DW-1:0] exp_r;
   logic fail_r;
   wire cnt_done = (cnt_r == '0);
   wire match = (din_s2_r == exp_r);
   wire last = (addr_r == ALAST);
   wire in_id = (st_r == otpps_pkg::OTPPS_IDRD);

   always_comb begin
      st_nxt = st_r;
      case (st_r)
         otpps_pkg::OTPPS_IDLE: begin
            if (start_prog) begin
               st_nxt = otpps_pkg::OTPPS_PWR_UP;
            end else if (start_id) begin
               st_nxt = otpps_pkg::OTPPS_IDRD;
            end
         end
         otpps_pkg::OTPPS_PWR_UP: if (cnt_done) st_nxt = otpps_pkg::OTPPS_SET;
         otpps_pkg::OTPPS_SET: if (cnt_done) st_nxt = otpps_pkg::OTPPS_PULSE;
         otpps_pkg::OTPPS_PULSE: begin
            if (cnt_done) begin
               st_nxt = (ph_r == otpps_pkg::OTPPS_PH_FIRST) ?
                  (last ? otpps_pkg::OTPPS_VRD : otpps_pkg::OTPPS_SET) :
                  otpps_pkg::OTPPS_VRD;
            end
         end
         otpps_pkg::OTPPS_VRD: if (cnt_done) st_nxt = otpps_pkg::OTPPS_VCMP;
         otpps_pkg::OTPPS_VCMP: begin
            if (match && last) begin
               st_nxt = otpps_pkg::OTPPS_PWR_DN;
            end else if (match) begin
               st_nxt = otpps_pkg::OTPPS_VRD;
            end else if (retry_r == RMAX) begin
               st_nxt = otpps_pkg::OTPPS_PWR_DN;
            end else begin
               st_nxt = otpps_pkg::OTPPS_SET;
            end
         end
         otpps_pkg::OTPPS_PWR_DN: if (cnt_done) st_nxt = otpps_pkg::OTPPS_RB;
         otpps_pkg::OTPPS_RB: if (cnt_done) st_nxt = otpps_pkg::OTPPS_RBCMP;
         otpps_pkg::OTPPS_RBCMP: begin
            st_nxt = (last || !match) ? otpps_pkg::OTPPS_DONE :
               otpps_pkg::OTPPS_RB;
         end
         otpps_pkg::OTPPS_IDRD: if (cnt_done) st_nxt = otpps_pkg::OTPPS_DONE;
         otpps_pkg::OTPPS_DONE: st_nxt = otpps_pkg::OTPPS_IDLE;
         default: st_nxt = otpps_pkg::OTPPS_IDLE;
      endcase
   end

   // Reload value of the wait counter for the state being entered
   wire [CW-1:0] cnt_load =
      (st_nxt == otpps_pkg::OTPPS_PULSE) ? PW_C - CW'(1) :
      (st_nxt == otpps_pkg::OTPPS_VRD || st_nxt == otpps_pkg::OTPPS_RB ||
       st_nxt == otpps_pkg::OTPPS_IDRD) ? OE_C : SU_C;
   wire entering = (st_nxt != st_r);

   always_ff @(posedge mclk) begin
      if (srst) begin
         st_r <= otpps_pkg::OTPPS_IDLE;
         cnt_r <= '0;
      end else begin
         st_r <= st_nxt;
         cnt_r <= entering ? cnt_load : (cnt_done ? cnt_r : cnt_r - CW'(1));
      end
   end

   // Address, phase, retry and outcome tracking
   always_ff @(posedge mclk) begin
      if (srst) begin
         addr_r <= '0;
         ph_r <= otpps_pkg::OTPPS_PH_FIRST;
         retry_r <= '0;
         fail_r <= 1'b0;
         pass <= 1'b0;
      end else begin
         case (st_r)
            otpps_pkg::OTPPS_IDLE: begin
               if (start_prog) begin
                  addr_r <= '0;
                  ph_r <= otpps_pkg::OTPPS_PH_FIRST;
                  fail_r <= 1'b0;
                  pass <= 1'b0;
               end
            end
            otpps_pkg::OTPPS_PULSE: begin
               if (cnt_done && ph_r == otpps_pkg::OTPPS_PH_FIRST) begin
                  addr_r <= addr_r + AW'(1);
                  if (last) begin
                     ph_r <= otpps_pkg::OTPPS_PH_VERIFY;
                     retry_r <= '0;
                  end
               end
            end
            otpps_pkg::OTPPS_VCMP: begin
               if (match) begin
                  retry_r <= '0;
                  addr_r <= addr_r + AW'(1);
               end else if (retry_r == RMAX) begin
                  fail_r <= 1'b1;
                  addr_r <= '0;
               end else begin
                  retry_r <= retry_r + 4'h1;
               end
               if (match && last) ph_r <= otpps_pkg::OTPPS_PH_READ;
            end
            otpps_pkg::OTPPS_RBCMP: begin
               addr_r <= addr_r + AW'(1);
               if (!match) fail_r <= 1'b1;
               if (last && match && !fail_r) pass <= 1'b1;
            end
            default: ;
         endcase
      end
   end

   // First pass walks to last address then needs a wrap before verify
   wire prog_on = !(st_r == otpps_pkg::OTPPS_IDLE ||
      st_r == otpps_pkg::OTPPS_IDRD || st_r == otpps_pkg::OTPPS_DONE ||
      st_r == otpps_pkg::OTPPS_RB || st_r == otpps_pkg::OTPPS_RBCMP);
   wire reading = (st_r == otpps_pkg::OTPPS_VRD ||
      st_r == otpps_pkg::OTPPS_VCMP || st_r == otpps_pkg::OTPPS_RB ||
      st_r == otpps_pkg::OTPPS_RBCMP || in_id);
   wire [AW-1:0] id_addr = AW'({id_sel} << `OTPPS_ID_SEL_BIT);

   ////////////////////////////////////////////////////////////////////////
   // Pin drivers, all registered
   always_ff @(posedge mclk) begin
      if (srst) begin
         mem_addr <= '0;
         data_out <= '0;
         data_oe_n <= 1'b1;
         chip_en_n <= 1'b1;
         out_en_n <= 1'b1;
         program_strobe_n <= 1'b1;
         id_mode_high_voltage_line <= 1'b0;
         vcc_prog <= 1'b0;
         vpp_prog <= 1'b0;
         exp_r <= '0;
         id_word <= '0;
      end else begin
         mem_addr <= in_id ? id_addr : addr_r;
         data_out <= src_data;
         exp_r <= in_id ? exp_r : src_data;
         data_oe_n <= reading || !prog_on;
         chip_en_n <= !(prog_on || reading);
         out_en_n <= !reading;
         program_strobe_n <= !(st_r == otpps_pkg::OTPPS_PULSE);
         id_mode_high_voltage_line <= in_id;
         vcc_prog <= prog_on;
         vpp_prog <= prog_on && vcc_prog && st_r != otpps_pkg::OTPPS_PWR_DN;
         if (in_id && cnt_done) id_word <= din_s2_r;
      end
   end

   assign src_addr = addr_r;
   assign busy = (st_r != otpps_pkg::OTPPS_IDLE);
   assign done = (st_r == otpps_pkg::OTPPS_DONE);

   ////////////////////////////////////////////////////////////////////////
   // Checks
   a_strobe_width: assert property (@(posedge mclk) disable iff (srst)
      $fell(program_strobe_n) |-> !program_strobe_n [*8])
      else $error("strobe pulse too short");
   // Length of the current strobe pulse, in clocks
   logic [CW-1:0] low_len_r;
   always_ff @(posedge mclk) begin
      if (srst) begin
         low_len_r <= '0;
      end else begin
         low_len_r <= program_strobe_n ? '0 : low_len_r + CW'(1);
      end
   end
   a_pulse_length: assert property (@(posedge mclk) disable iff (srst)
      $rose(program_strobe_n) |-> low_len_r == PW_C)
      else $error("strobe pulse length off");
   a_vpp_after_vcc: assert property (@(posedge mclk) disable iff (srst)
      vpp_prog |-> vcc_prog)
      else $error("programming supply without main supply");
   a_strobe_io: assert property (@(posedge mclk) disable iff (srst)
      !program_strobe_n |-> out_en_n && !chip_en_n)
      else $error("strobe during read");
   a_id_lines: assert property (@(posedge mclk) disable iff (srst)
      id_mode_high_voltage_line |-> mem_addr[AW-1:1] == '0
      && program_strobe_n)
      else $error("id readout address bits not low");
   a_retry_cap: assert property (@(posedge mclk) disable iff (srst)
      retry_r <= RMAX)
      else $error("retry count beyond limit");
   a_fail_stop: assert property (@(posedge mclk) disable iff (srst)
      st_r == otpps_pkg::OTPPS_VCMP && !match && retry_r == RMAX
      |=> st_r == otpps_pkg::OTPPS_PWR_DN)
      else $error("no stop after retry limit");
   a_start_zero: assert property (@(posedge mclk) disable iff (srst)
      st_r == otpps_pkg::OTPPS_IDLE && start_prog |=> addr_r == '0)
      else $error("sequence not at address zero");
   a_pass_clean: assert property (@(posedge mclk) disable iff (srst)
      $rose(pass) |-> !fail_r)
      else $error("pass with failure recorded");
endmodule
`default_nettype wire

// [bench/otpps_mem_model.sv]
// Purpose: Behavioural one-time-programmable memory for the programmer
// Assumes: Pins sampled on mclk; erased words read all ones
// Notes: viol latches vpp without vcc, strobe without vpp, chip enable or data drive, bad width or first pulse off address zero
`timescale 1ns/1ns
`default_nettype none
module otpps_mem_model #(
   parameter int AW = 3,
   parameter int PW_CYC = 20,
   parameter logic [7:0] MAKER_ID = 8'h5A,
   parameter logic [7:0] TYPE_ID = 8'hC3
) (
   input wire logic mclk,
   input wire logic erase,
   input wire logic [AW-1:0] mem_addr,
   input wire logic [15:0] data_out,
   input wire logic data_oe_n,
   output logic [15:0] data_outputs,
   input wire logic chip_en_n,
   input wire logic out_en_n,
   input wire logic program_strobe_n,
   input wire logic id_mode_high_voltage_line,
   input wire logic vcc_prog,
   input wire logic vpp_prog,
   output logic viol
);
   logic [15:0] mem [2**AW];
   int need [2**AW];
   int pulses [2**AW];
   int low_cnt;
   logic first_done;
   logic [15:0] last, pd;
   logic [AW-1:0] pa;
   wire rd_en = !chip_en_n && !out_en_n && program_strobe_n;
   wire id_ok = id_mode_high_voltage_line && mem_addr[AW-1:1] == '0;
   wire [15:0] id_val = {8'h00, mem_addr[0] ? TYPE_ID : MAKER_ID};
   // Released bus shows a changing pattern, never the last value
   assign data_outputs = !data_oe_n ? data_out : !rd_en ? ~last :
      id_ok ? id_val : id_mode_high_voltage_line ? ~last : mem[mem_addr];
   always @(posedge mclk) begin
      last <= data_outputs;
      if (vpp_prog && !vcc_prog) viol <= 1'b1;
      low_cnt <= program_strobe_n ? 0 : low_cnt + 1;
      if (!program_strobe_n) begin
         pa <= mem_addr;
         pd <= data_out;
         if (!vpp_prog || chip_en_n || data_oe_n) viol <= 1'b1;
      end else if (low_cnt != 0) begin
         if (low_cnt * 100 < PW_CYC * 95) viol <= 1'b1;
         if (low_cnt * 100 > PW_CYC * 105) viol <= 1'b1;
         if (!first_done && pa != '0) viol <= 1'b1;
         first_done <= 1'b1;
         pulses[pa] <= pulses[pa] + 1;
         if (pulses[pa] + 1 >= need[pa]) mem[pa] <= mem[pa] & pd;
      end
      if (erase) begin
         viol <= 1'b0;
         first_done <= 1'b0;
         for (int i = 0; i < 2**AW; i++) begin
            mem[i] <= 16'hFFFF;
            need[i] = 1;
            pulses[i] <= 0;
         end
      end
   end
endmodule
`default_nettype wire

// [bench/tb.sv]
// Purpose: Self-checking bench for the memory programmer
// Assumes: Short pulse and address widths to keep runs brief
// Notes: Done results are checked against a queue of notes
`timescale 1ns/1ns
`default_nettype none
module tb;
   localparam int AW = 3;
   localparam int NW = 2**AW;
   localparam int PW = 20;
   localparam logic [7:0] MAKER = 8'h5A; // Arbitrary value
   localparam logic [7:0] PTYPE = 8'hC3; // Arbitrary value
   logic mclk, srst, start_prog, start_id, id_sel, erase, viol, pass, busy;
   logic data_oe_n, chip_en_n, out_en_n, program_strobe_n, hv, vcc, vpp;
   logic done;
   logic [15:0] src_data, data_out, data_outputs, id_word;
   logic [AW-1:0] src_addr, mem_addr;
   logic [15:0] src_tab [NW];
   logic [16:0] exp_q [$];
   logic [16:0] note;
   int mismatches, checks, cycles, seed;
   otpps_programmer #(.AW(AW), .DW(16), .PW_CYC(PW)) uut (.mclk(mclk),
      .srst(srst), .start_prog(start_prog), .start_id(start_id),
      .id_sel(id_sel), .src_data(src_data), .src_addr(src_addr),
      .mem_addr(mem_addr), .data_out(data_out), .data_oe_n(data_oe_n),
      .data_outputs(data_outputs), .chip_en_n(chip_en_n),
      .out_en_n(out_en_n), .program_strobe_n(program_strobe_n),
      .id_mode_high_voltage_line(hv), .vcc_prog(vcc), .vpp_prog(vpp),
      .busy(busy), .done(done), .pass(pass), .id_word(id_word));
   otpps_mem_model #(.AW(AW), .PW_CYC(PW), .MAKER_ID(MAKER),
      .TYPE_ID(PTYPE)) dev (.mclk(mclk), .erase(erase),
      .mem_addr(mem_addr), .data_out(data_out), .data_oe_n(data_oe_n),
      .data_outputs(data_outputs), .chip_en_n(chip_en_n),
      .out_en_n(out_en_n), .program_strobe_n(program_strobe_n),
      .id_mode_high_voltage_line(hv), .vcc_prog(vcc), .vpp_prog(vpp),
      .viol(viol));
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic check(string what, logic [15:0] exp, logic [15:0] got);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////
   always @(posedge mclk) begin
      cycles++;
      if (cycles > 30000) begin
         mismatches++;
         report_and_stop();
      end
   end
   always @(negedge mclk) begin
      src_data <= src_tab[src_addr];
      if (srst === 1'b0 && done === 1'b1) begin
         if (exp_q.size() == 0) check("spare done", 16'h0, 16'h1);
         else begin
            note = exp_q.pop_front();
            if (note[16]) check("pass", {15'h0, note[0]}, {15'h0, pass});
            else check("id_word", note[15:0], id_word);
            check("supplies", 16'h0, {14'h0, vcc, vpp});
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic start(logic prog, logic sel, logic exp_pass);
      exp_q.push_back(prog ? {1'b1, 15'h0, exp_pass} :
         {9'h0, sel ? PTYPE : MAKER});
      id_sel = sel;
      start_prog = prog;
      start_id = !prog;
      @(negedge mclk);
      start_prog = 1'b0;
      start_id = 1'b0;
      repeat (2) @(negedge mclk);
      for (int i = 0; i < 30000 && busy !== 1'b0; i++) @(negedge mclk);
      repeat (2) @(negedge mclk);
   endtask
   task automatic prog_run(string name, int slow, int nd, int pulses);
      erase = 1'b1;
      for (int i = 0; i < NW; i++) src_tab[i] = 16'($random(seed));
      src_tab[slow] = src_tab[slow] & 16'h7FFF;
      @(negedge mclk);
      erase = 1'b0;
      @(negedge mclk);
      dev.need[slow] = nd;
      fork
         start(1'b1, 1'b0, pulses <= 10);
         begin
            repeat (60) @(negedge mclk);
            start_id = 1'b1;
            @(negedge mclk);
            start_id = 1'b0;
         end
      join
      for (int i = 0; i < NW; i++) begin
         check("pulses", 16'(i == slow ? pulses : 1), 16'(dev.pulses[i]));
         if (i != slow || pulses <= 10) check("word", src_tab[i], dev.mem[i]);
      end
      check("misuse", 16'h0, {15'h0, viol});
      $display("test %s finished", name);
   endtask
   initial begin
      seed = 32'h4897;
      mismatches = 0;
      checks = 0;
      cycles = 0;
      srst = 1'b1;
      erase = 1'b1;
      start_prog = 1'b0;
      start_id = 1'b0;
      id_sel = 1'b0;
      src_data = 16'h0;
      repeat (20) @(negedge mclk);
      srst = 1'b0;
      prog_run("clean", 0, 1, 1);
      prog_run("retry", NW - 1, 3, 3);
      prog_run("failing", 0, 99, 11);
      for (int s = 0; s < 2; s++) start(1'b0, s[0], 1'b0);
      check("pending", 16'h0, 16'(exp_q.size()));
      $display("test ident finished");
      report_and_stop();
   end
endmodule
`default_nettype wire
